//--- core/mcsd_core.sv
`timescale 1ns/1ps
// How it works
// - selects follow every memory cycle in range, CPU or DMA alike.
// - six select outputs: one upper, one lower, four mid-range.
// - sizes are powers of two, 2K-128K; upper and lower add 1K, 256K.
// - upper region always ends at the top; only its floor is set.
// - upper register at A0H, bits 6-15 give the region start.
// - after reset the upper region is 1K and live at once.
// - upper select when address bits 19-4 >= register with low six zero.
// - lower register at A2H, region from zero, bits 6-15 give limit.
// - lower select stays off until its register is first accessed.
// - lower select when address bits 19-4 <= register with low six ones.
// - one-hot bits 8-14 at A8H set mid block, 8K up to 512K.
// - mid block split in four quarters, line zero lowest.
// - mid base at A6H, bits 15-9 give address bits 19-13.
// - mid selects stay off until both mid registers are accessed.
// - each region's ready field sets its waits; mid base covers all four.
// - upper register leaves reset as FFFBH: 1K, three waits, ext ready.
// - ready bits 1-0 give waits; bit 2 set ignores external ready.
// - internal and external waits overlap; the longer one counts.
// - all selects high while reset is applied.
module mcsd_core (
   // clock and reset
   input  wire logic        clk_sys_in,
   input  wire logic        rst_in,
   // bus cycle from the CPU or the DMA unit
   input  wire logic [19:0] address_in,
   input  wire logic        mem_cycle_in,
   input  wire logic        ext_ready_in,
   // control-block register port
   input  wire logic [7:0]  reg_offset_in,
   input  wire logic        reg_write_in,
   input  wire logic        reg_read_in,
   input  wire logic [15:0] reg_wdata_in,
   output logic [15:0]      reg_rdata_out,
   // memory selects, active low
   output logic             upper_region_select_n_out,
   output logic             lower_region_select_n_out,
   output logic [3:0]       mid_region_select_n_out,
   // ready towards the bus unit
   output logic [2:0]       ready_mode_field_out,
   output logic             bus_ready_out
);
   logic [15:0] upper_region_config;
   logic [15:0] lower_region_config;
   logic [15:0] mid_region_base;
   logic [15:0] mid_region_size;
   logic        lower_accessed;
   logic        base_accessed;
   logic        size_accessed;
   logic        cycle_seen;
   logic        start_pulse;

   // returns the mask of offset bits inside the mid-range block
   function automatic logic [19:0] mid_block_mask(
      input logic [6:0] size_field
   );
      logic [19:0] mask;
      mask = '0;
      for (int k = 0; k < mcsd_pkg::MID_SIZE_W; k++) begin
         if (size_field[k]) begin
            mask = (mcsd_pkg::MID_MIN_BLOCK << k) - mcsd_pkg::ONE_ADDR;
         end
      end
      return mask;
   endfunction

   // returns which quarter of the mid block an address falls in
   function automatic logic [1:0] mid_quarter(
      input logic [19:0] addr,
      input logic [6:0]  size_field
   );
      logic [1:0] q;
      q = '0;
      for (int k = 0; k < mcsd_pkg::MID_SIZE_W; k++) begin
         if (size_field[k]) begin
            q = addr[mcsd_pkg::QUARTER_LSB + k +: 2];
         end
      end
      return q;
   endfunction

   // register port decode
   wire hit_upper = (reg_offset_in == mcsd_pkg::OFS_UPPER_CFG);
   wire hit_lower = (reg_offset_in == mcsd_pkg::OFS_LOWER_CFG);
   wire hit_base = (reg_offset_in == mcsd_pkg::OFS_MID_BASE);
   wire hit_size = (reg_offset_in == mcsd_pkg::OFS_MID_SIZE);
   wire reg_touch = reg_write_in | reg_read_in;

   wire [15:0] next_rdata = hit_upper ? upper_region_config
                          : hit_lower ? lower_region_config
                          : hit_base ? mid_region_base
                          : hit_size ? mid_region_size
                          : 16'h0000;

   // address decode
   wire [15:0] addr_hi = address_in[19:mcsd_pkg::ADDR_HI_LSB];
   wire [15:0] upper_floor =
      {upper_region_config[15:mcsd_pkg::LIMIT_LSB], mcsd_pkg::UPPER_FILL};
   wire [15:0] lower_ceiling =
      {lower_region_config[15:mcsd_pkg::LIMIT_LSB], mcsd_pkg::LOWER_FILL};
   wire        upper_hit = (addr_hi >= upper_floor);
   wire        lower_hit = lower_accessed
                         & (addr_hi <= lower_ceiling);

   wire [6:0]  size_field =
      mid_region_size[mcsd_pkg::MID_SIZE_LSB +: mcsd_pkg::MID_SIZE_W];
   wire [19:0] mid_base_addr =
      {mid_region_base[15:mcsd_pkg::MID_BASE_LSB],
       {mcsd_pkg::MID_ADDR_LSB{1'b0}}};
   wire [19:0] mid_mask = mid_block_mask(size_field);
   wire        mid_in_block =
      ((address_in & ~mid_mask) == (mid_base_addr & ~mid_mask));
   wire        mid_hit = base_accessed & size_accessed & mid_in_block;
   wire [1:0]  quarter = mid_quarter(address_in, size_field);

   // selects follow the cycle regardless of who owns the bus
   wire       next_upper_n = ~(mem_cycle_in & upper_hit);
   wire       next_lower_n = ~(mem_cycle_in & lower_hit);
   wire [3:0] next_mid_n = (mem_cycle_in & mid_hit)
                         ? ~(mcsd_pkg::MID_LINE0 << quarter)
                         : mcsd_pkg::MID_ALL_OFF;

   // ranges never overlap, so this priority only matters for bad setups
   wire [2:0] next_mode = upper_hit ? upper_region_config[2:0]
                        : lower_hit ? lower_region_config[2:0]
                        : mid_hit ? mid_region_base[2:0]
                        : mcsd_pkg::NO_REGION_MODE;
   assign start_pulse = mem_cycle_in & ~cycle_seen;

   // region registers; the upper one comes up as a live 1K region
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         upper_region_config <= mcsd_pkg::UPPER_CFG_RESET;
         lower_region_config <= mcsd_pkg::CFG_CLEAR;
         mid_region_base <= mcsd_pkg::CFG_CLEAR;
         mid_region_size <= mcsd_pkg::CFG_CLEAR;
      end else if (reg_write_in) begin
         if (hit_upper) upper_region_config <= reg_wdata_in;
         if (hit_lower) lower_region_config <= reg_wdata_in;
         if (hit_base) mid_region_base <= reg_wdata_in;
         if (hit_size) mid_region_size <= reg_wdata_in;
      end
   end

   // a read counts as an access as well as a write
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         lower_accessed <= 1'b0;
         base_accessed <= 1'b0;
         size_accessed <= 1'b0;
      end else begin
         if (reg_touch & hit_lower) lower_accessed <= 1'b1;
         if (reg_touch & hit_base) base_accessed <= 1'b1;
         if (reg_touch & hit_size) size_accessed <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         reg_rdata_out <= 16'h0000;
      end else if (reg_read_in) begin
         reg_rdata_out <= next_rdata;
      end
   end

   // selects are registered so they never glitch between addresses
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         upper_region_select_n_out <= 1'b1;
         lower_region_select_n_out <= 1'b1;
         mid_region_select_n_out <= mcsd_pkg::MID_ALL_OFF;
      end else begin
         upper_region_select_n_out <= next_upper_n;
         lower_region_select_n_out <= next_lower_n;
         mid_region_select_n_out <= next_mid_n;
      end
   end

   // the ready mode is frozen for the whole cycle once it starts
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         cycle_seen <= 1'b0;
         ready_mode_field_out <= mcsd_pkg::NO_REGION_MODE;
      end else begin
         cycle_seen <= mem_cycle_in;
         if (start_pulse) ready_mode_field_out <= next_mode;
      end
   end

   logic start_q;
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         start_q <= 1'b0;
      end else begin
         start_q <= start_pulse;
      end
   end

   mcsd_wait_gen u_wait (
      .clk_sys_in   (clk_sys_in),
      .rst_in       (rst_in),
      .start_in     (start_q),
      .mode_in      (ready_mode_field_out),
      .ext_ready_in (ext_ready_in),
      .ready_out    (bus_ready_out)
   );

   // checks
   a_reset_idle: assert property (
      @(posedge clk_sys_in)
      rst_in |-> upper_region_select_n_out && lower_region_select_n_out
                 && mid_region_select_n_out == 4'hF)
      else $error("select active during reset");
   a_upper_reset: assert property (
      @(posedge clk_sys_in)
      $fell(rst_in) |-> upper_region_config == 16'hFFFB)
      else $error("upper register wrong after reset");
   a_upper_sel: assert property (
      @(posedge clk_sys_in) disable iff (rst_in)
      mem_cycle_in && address_in[19:4] >=
         {upper_region_config[15:6], 6'h00}
      |=> !upper_region_select_n_out)
      else $error("upper select missed");
   a_upper_below: assert property (
      @(posedge clk_sys_in) disable iff (rst_in)
      mem_cycle_in && address_in[19:4] < {upper_region_config[15:6], 6'h00}
      |=> upper_region_select_n_out)
      else $error("upper select below its floor");
   a_upper_write: assert property (
      @(posedge clk_sys_in) disable iff (rst_in)
      reg_write_in && reg_offset_in == 8'hA0
      |=> upper_region_config == $past(reg_wdata_in))
      else $error("upper register write lost");
   a_lower_gate: assert property (
      @(posedge clk_sys_in) disable iff (rst_in)
      !lower_accessed |=> lower_region_select_n_out)
      else $error("lower select before access");
   a_lower_sel: assert property (
      @(posedge clk_sys_in) disable iff (rst_in)
      mem_cycle_in && lower_accessed && address_in[19:4] <=
         {lower_region_config[15:6], 6'h3F}
      |=> !lower_region_select_n_out)
      else $error("lower select missed");
   a_lower_above: assert property (
      @(posedge clk_sys_in) disable iff (rst_in)
      mem_cycle_in && address_in[19:4] > {lower_region_config[15:6], 6'h3F}
      |=> lower_region_select_n_out)
      else $error("lower select above its limit");
   a_lower_read: assert property (
      @(posedge clk_sys_in) disable iff (rst_in)
      reg_read_in && reg_offset_in == 8'hA2
      |=> reg_rdata_out == $past(lower_region_config))
      else $error("lower register read wrong");
   a_mid_gate: assert property (
      @(posedge clk_sys_in) disable iff (rst_in)
      !(base_accessed && size_accessed)
      |=> mid_region_select_n_out == 4'hF)
      else $error("mid select before both accesses");
   a_mid_quarter: assert property (
      @(posedge clk_sys_in) disable iff (rst_in)
      mem_cycle_in && mid_hit
      |=> $countones(~mid_region_select_n_out) == 1
          && !mid_region_select_n_out[$past(quarter)])
      else $error("mid quarter wrong");
   a_mid_outside: assert property (
      @(posedge clk_sys_in) disable iff (rst_in)
      mem_cycle_in && !mid_in_block
      |=> mid_region_select_n_out == 4'hF)
      else $error("mid select outside its block");
   a_mid_size_write: assert property (
      @(posedge clk_sys_in) disable iff (rst_in)
      reg_write_in && reg_offset_in == 8'hA8
      |=> mid_region_size == $past(reg_wdata_in))
      else $error("mid size write lost");
   a_outside_off: assert property (
      @(posedge clk_sys_in) disable iff (rst_in)
      !mem_cycle_in || !(upper_hit || lower_hit || mid_hit)
      |=> upper_region_select_n_out && lower_region_select_n_out
          && mid_region_select_n_out == 4'hF)
      else $error("select active outside regions");
   a_mode_upper: assert property (
      @(posedge clk_sys_in) disable iff (rst_in)
      start_pulse && upper_hit
      |=> ready_mode_field_out == $past(upper_region_config[2:0]))
      else $error("upper ready mode not applied");
   a_mode_lower: assert property (
      @(posedge clk_sys_in) disable iff (rst_in)
      start_pulse && lower_hit && !upper_hit
      |=> ready_mode_field_out == $past(lower_region_config[2:0]))
      else $error("lower ready mode not applied");
   a_mode_mid: assert property (
      @(posedge clk_sys_in) disable iff (rst_in)
      start_pulse && mid_hit && !upper_hit && !lower_hit
      |=> ready_mode_field_out == $past(mid_region_base[2:0]))
      else $error("mid ready mode not applied");
   a_mode_held: assert property (
      @(posedge clk_sys_in) disable iff (rst_in)
      mem_cycle_in && !start_pulse
      |=> $stable(ready_mode_field_out))
      else $error("ready mode changed inside a cycle");

   c_upper: cover property (@(posedge clk_sys_in) disable iff (rst_in)
      !upper_region_select_n_out);
   c_lower: cover property (@(posedge clk_sys_in) disable iff (rst_in)
      !lower_region_select_n_out);
   c_mid_top: cover property (@(posedge clk_sys_in) disable iff (rst_in)
      !mid_region_select_n_out[3]);
endmodule

//--- common/mcsd_pkg.sv
package mcsd_pkg;
   // widths of the processor address and of the control-block registers
   localparam int ADDR_W = 20;
   localparam int DATA_W = 16;
   localparam int OFS_W = 8;
   localparam int READY_W = 3;
   localparam int MID_SIZE_W = 7;

   // control-block offsets of the four region registers
   localparam logic [7:0] OFS_UPPER_CFG = 8'hA0;
   localparam logic [7:0] OFS_LOWER_CFG = 8'hA2;
   localparam logic [7:0] OFS_MID_BASE = 8'hA6;
   localparam logic [7:0] OFS_MID_SIZE = 8'hA8;

   // values after reset
   localparam logic [15:0] UPPER_CFG_RESET = 16'hFFFB;
   localparam logic [15:0] CFG_CLEAR = 16'h0000;

   // field positions
   localparam int LIMIT_LSB = 6;
   localparam int MID_BASE_LSB = 9;
   localparam int MID_SIZE_LSB = 8;
   localparam int MID_ADDR_LSB = 13;
   localparam int QUARTER_LSB = 11;
   localparam int ADDR_HI_LSB = 4;
   localparam int READY_WAIT_MSB = 1;
   localparam int READY_IGNORE_EXT = 2;

   // fill of the six low limit bits for each compare
   localparam logic [5:0] UPPER_FILL = 6'h00;
   localparam logic [5:0] LOWER_FILL = 6'h3F;

   // smallest mid-range block, 8K, as a byte count; minus one gives its offset mask
   localparam logic [19:0] MID_MIN_BLOCK = 20'h02000;
   localparam logic [19:0] ONE_ADDR = 20'h00001;

   // ready mode used when no region is hit: no waits, external ready
   localparam logic [2:0] NO_REGION_MODE = 3'h0;
   localparam logic [3:0] MID_ALL_OFF = 4'hF;
   localparam logic [3:0] MID_LINE0 = 4'h1;
   localparam logic [1:0] WAIT_NONE = 2'h0;
   localparam logic [1:0] WAIT_ONE = 2'h1;
endpackage

//--- core/mcsd_wait_gen.sv
`timescale 1ns/1ps
module mcsd_wait_gen (
   // clock and reset
   input  wire logic       clk_sys_in,
   input  wire logic       rst_in,
   // cycle start and mode of the selected region
   input  wire logic       start_in,
   input  wire logic [2:0] mode_in,
   input  wire logic       ext_ready_in,
   // combined ready
   output logic            ready_out
);
   logic [1:0] count;
   logic [1:0] next_count;
   logic       next_ready;
   logic       waits_done;

   // internal waits run in parallel with external ready, so the longer wins
   assign next_count = start_in ? mode_in[mcsd_pkg::READY_WAIT_MSB:0]
                     : (count != mcsd_pkg::WAIT_NONE)
                       ? count - mcsd_pkg::WAIT_ONE
                       : mcsd_pkg::WAIT_NONE;
   assign waits_done = (next_count == mcsd_pkg::WAIT_NONE);
   assign next_ready = waits_done
                     & (mode_in[mcsd_pkg::READY_IGNORE_EXT]
                        | ext_ready_in);

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         count <= mcsd_pkg::WAIT_NONE;
         ready_out <= 1'b0;
      end else begin
         count <= next_count;
         ready_out <= next_ready;
      end
   end

   a_wait_three: assert property (
      @(posedge clk_sys_in) disable iff (rst_in)
      start_in && mode_in == 3'h7 |=> !ready_out [*3] ##1 ready_out)
      else $error("three internal waits not honoured");
   a_ext_holds: assert property (
      @(posedge clk_sys_in) disable iff (rst_in)
      !mode_in[2] && !ext_ready_in && !start_in |=> !ready_out)
      else $error("ready given while external ready low");
   c_ext_stretch: cover property (@(posedge clk_sys_in) disable iff (rst_in)
      start_in && mode_in == 3'h1 ##1 !ready_out [*3] ##1 ready_out);
endmodule

//--- testbench/mcsd_mem_model.sv
`timescale 1ns/1ps
module mcsd_mem_model (
   // selects from the decoder
   input  wire logic       upper_region_select_n_in,
   input  wire logic       lower_region_select_n_in,
   input  wire logic [3:0] mid_region_select_n_in,
   // slow device holds ready low for the whole selected cycle
   input  wire logic       slow_in,
   output logic            ext_ready_out
);
   logic any_sel;
   // ready line has a pull-up, so it reads high while nothing is selected
   assign any_sel = ~(upper_region_select_n_in & lower_region_select_n_in
                      & (&mid_region_select_n_in));
   // follows the registered selects, so it is settled before the next edge
   assign ext_ready_out = ~(slow_in & any_sel);
endmodule

//--- testbench/memory_chip_select_decoder_test.sv
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin failures++; \
$display("ERROR %0t: got %h exp %h", $time, (a), (b)); end end
module memory_chip_select_decoder_test;
   logic        clk_sys_in, rst_in, mem_cycle_in, ext_ready_in, slow;
   logic        reg_write_in, reg_read_in, upper_n, lower_n, bus_ready_out;
   logic [19:0] address_in;
   logic [7:0]  reg_offset_in;
   logic [15:0] reg_wdata_in, reg_rdata_out, u, l, b, s, want;
   logic [3:0]  mid_n;
   logic [2:0]  mode, acc;
   logic [11:0] exp_q[$], cur;
   logic [15:0] rd_q[$];
   logic        mc_prev = 0, st, rd;
   int          failures = 0, cmp_count = 0, idx, lows;
   int          bs, sz;

   mcsd_core u_mcsd_core (.clk_sys_in, .rst_in, .address_in, .mem_cycle_in,
      .ext_ready_in, .reg_offset_in, .reg_write_in, .reg_read_in,
      .reg_wdata_in, .reg_rdata_out, .upper_region_select_n_out(upper_n),
      .lower_region_select_n_out(lower_n), .mid_region_select_n_out(mid_n),
      .ready_mode_field_out(mode), .bus_ready_out);
   mcsd_mem_model u_mcsd_mem_model (
      .upper_region_select_n_in(upper_n), .lower_region_select_n_in(lower_n),
      .mid_region_select_n_in(mid_n), .slow_in(slow),
      .ext_ready_out(ext_ready_in));

   initial begin
      clk_sys_in = 0;
      forever #2.5 clk_sys_in = ~clk_sys_in;
   end

   // {selects, mode, waits}; priority only matters if software overlaps
   function automatic logic [11:0] expect_of(input logic [19:0] a);
      logic [5:0]  sel;
      logic [2:0]  m;
      logic [19:0] blk, base;
      int          k;
      sel = 6'h3F;
      m = 3'h0;
      k = 0;
      for (int i = 0; i < 7; i++) if (s[8+i]) k = i;
      blk = 20'h02000 << k;
      base = {b[15:9], 13'h0000};
      if (acc[2] && acc[1] && a >= base && (a - base) < blk) begin
         sel[3:0] = ~(4'h1 << ((a - base) >> (11 + k)));
         m = b[2:0];
      end
      if (acc[0] && a[19:4] <= {l[15:6], 6'h3F}) begin
         sel[4] = 1'b0;
         m = l[2:0];
      end
      if (a[19:4] >= {u[15:6], 6'h00}) begin
         sel[5] = 1'b0;
         m = u[2:0];
      end
      return {sel, m, 1'b0, m[1:0]};
   endfunction

   function automatic logic [15:0] regval(input logic [7:0] o);
      case (o)
         8'hA0: return u;
         8'hA2: return l;
         8'hA6: return b;
         8'hA8: return s;
         default: return 16'h0000;
      endcase
   endfunction

   task automatic wr(input logic [7:0] o, input logic [15:0] d);
      @(posedge clk_sys_in) #1;
      reg_offset_in = o;
      reg_wdata_in = d;
      reg_write_in = 1;
      acc = acc | {o == 8'hA8, o == 8'hA6, o == 8'hA2};
      case (o)
         8'hA0: u = d;
         8'hA2: l = d;
         8'hA6: b = d;
         8'hA8: s = d;
         default: ;
      endcase
      @(posedge clk_sys_in) #1;
      reg_write_in = 0;
   endtask

   task automatic rdreg(input logic [7:0] o);
      @(posedge clk_sys_in) #1;
      reg_offset_in = o;
      reg_read_in = 1;
      rd_q.push_back(regval(o));
      acc = acc | {o == 8'hA8, o == 8'hA6, o == 8'hA2};
      @(posedge clk_sys_in) #1;
      reg_read_in = 0;
   endtask

   task automatic mem(input logic [19:0] a);
      logic [11:0] e;
      e = expect_of(a);
      @(posedge clk_sys_in) #1;
      address_in = a;
      mem_cycle_in = 1;
      slow = 1'($urandom % 2);
      // a slow device on a region that uses external ready stalls throughout
      if (slow && !e[5] && e[11:6] != 6'h3F) e[2:0] = 3'h7;
      exp_q.push_back(e);
      repeat (8) @(posedge clk_sys_in);
      #1 mem_cycle_in = 0;
   endtask

   task automatic do_reset;
      @(posedge clk_sys_in) #1;
      rst_in = 1;
      repeat (16) @(posedge clk_sys_in);
      #1 `CHK({upper_n, lower_n, mid_n}, 6'h3F);
      rst_in = 0;
      u = 16'hFFFB;
      {l, b, s, acc} = '0;
   endtask

   task tally_and_finish;
      $display("compares %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   always @(posedge clk_sys_in) begin
      st = mem_cycle_in & ~mc_prev & ~rst_in;
      mc_prev = mem_cycle_in;
      rd = reg_read_in & ~rst_in;
      #2;
      if (rd) begin
         want = rd_q.pop_front();
         `CHK(reg_rdata_out, want);
      end
      if (st) begin
         cur = exp_q.pop_front();
         idx = 0;
         lows = 0;
         `CHK({upper_n, lower_n, mid_n}, cur[11:6]);
         `CHK(mode, cur[5:3]);
      end
      if (mc_prev) begin
         if (idx > 0 && bus_ready_out !== 1'b1) lows++;
         if (idx == 7) `CHK(3'(lows), cur[2:0]);
         idx++;
      end
   end

   initial begin
      repeat (100000) @(posedge clk_sys_in);
      failures++;
      tally_and_finish;
   end

   initial begin
      {rst_in, mem_cycle_in, reg_write_in, reg_read_in, slow} = 5'h01;
      {address_in, reg_offset_in, reg_wdata_in} = '0;
      void'($urandom(90));
      // reset rises after time zero so the flops never miss its edge
      #1 rst_in = 1;
      do_reset;
      rdreg(8'hA0);
      mem(20'hFFC00);
      mem(20'hFFBFF);
      mem(20'h00000);
      wr(8'hA4, 16'($urandom));
      rdreg(8'hA4);
      wr(8'hA6, 16'h4000);
      mem(20'h40000);
      for (int i = 0; i < 9; i++) begin
         bs = 32'h100000 - (1024 << i);
         wr(8'hA0, (16'(bs >> 4) & 16'hFFC0) | 16'h0038
                   | 16'(i % 8));
         rdreg(8'hA0);
         mem(20'(bs));
         mem(20'(bs - 1));
         mem(20'(bs + $urandom % (1024 << i)));
      end
      for (int i = 0; i < 9; i++) begin
         bs = (1024 << i) - 1;
         wr(8'hA2, (16'(bs >> 4) & 16'hFFC0) | 16'h0038
                   | 16'(7 - i % 8));
         rdreg(8'hA2);
         mem(20'(bs));
         mem(20'(bs + 1));
         mem(20'($urandom % bs));
      end
      for (int k = 0; k < 6; k++) begin
         sz = 2048 << k;
         wr(8'hA6, 16'h4000 | 16'(k));
         wr(8'hA8, (16'h0100 << k) | 16'($urandom % 256));
         rdreg(8'hA8);
         for (int q = 0; q < 4; q++)
            mem(20'(32'h40000 + q * sz + $urandom % sz));
         mem(20'(32'h40000 + 4 * sz));
      end
      // the 512K block sits at zero with the lower region untouched
      do_reset;
      wr(8'hA6, 16'h0005);
      wr(8'hA8, 16'h4000);
      for (int q = 0; q < 4; q++) mem(20'(q * 32'h20000));
      mem(20'h80000);
      repeat (4) @(posedge clk_sys_in);
      tally_and_finish;
   end
endmodule
